// ### core/spp_pkg.sv
package spp_pkg;
    // opcodes seen on the link
    localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] OP_READ_STATUS    = 8'h05;
    localparam logic [7:0] OP_ERASE_SUSPEND  = 8'h75;
    localparam logic [7:0] OP_ERASE_PERSIST  = 8'he4;
    localparam logic [7:0] OP_READ_PROT      = 8'h2b;
    localparam logic [7:0] OP_PROG_PROT      = 8'h2f;
    localparam logic [7:0] OP_READ_LOCK      = 8'ha7;
    localparam logic [7:0] OP_CLEAR_LOCK     = 8'ha6;
    localparam logic [7:0] OP_SET_HOLD       = 8'h91;
    localparam logic [7:0] OP_READ_SECRET    = 8'he7;
    localparam logic [7:0] OP_PROG_SECRET    = 8'he8;
    localparam logic [7:0] OP_UNLOCK_SECRET  = 8'he9;

    // frame lengths in link clocks, opcode included
    localparam logic [7:0] FRAME_OP_BITS     = 8'h08;
    localparam logic [7:0] FRAME_PROT_BITS   = 8'h18;
    localparam logic [7:0] FRAME_SECRET_BITS = 8'h48;

    // field positions
    localparam int STAT_WIP_BIT        = 0;
    localparam int STAT_WEL_BIT        = 1;
    localparam int LOCK_PERSIST_BIT    = 0;
    localparam int LOCK_HOLD_BIT       = 7;
    localparam int CFG_SECRET_MODE_BIT = 2;

    // reset values
    localparam logic [15:0] CFG_RESET    = 16'hffff;
    localparam logic [7:0]  LOCK_RESET   = 8'h01;
    localparam logic [63:0] SECRET_RESET = 64'hffff_ffff_ffff_ffff;

    // timing, system clock 40 MHz
    localparam int SYS_PERIOD_NS   = 25;
    localparam int PROG_TIME_NS    = 2000;
    localparam int ERASE_TIME_NS   = 10000;
    localparam int CS_GAP_NS       = 100;
    localparam int PROG_CYCLES     = (PROG_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int ERASE_CYCLES    = (ERASE_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int CS_GAP_CYCLES   = (CS_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int SCK_HALF_CYCLES = 4;

    // stream position to value bit: low byte first, msb first per byte
    function automatic logic [5:0] stream_idx(input logic [6:0] pos);
        return {pos[5:3], ~pos[2:0]};
    endfunction : stream_idx
endpackage : spp_pkg

// ### core/spp_if.sv
interface spp_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport dev  (input cs_n, input sck, input mosi, output miso, output miso_oe);
    modport host (output cs_n, output sck, output mosi, input miso);
endinterface : spp_if

// ### core/spp_device.sv
module spp_device
    import spp_pkg::*;
#(
    parameter int PPB_COUNT = 32
) (
    input  wire logic                 sys_clk_in,          // timed-operation clock
    input  wire logic                 nrst_in,             // async reset, active low
    spp_if.dev                        link,                // serial link to the host
    output logic                      wip_out,             // operation running
    output logic                      wel_out,             // write enable latch
    output logic [15:0]               cfg_out,             // protection config
    output logic [7:0]                lock_out,            // lock register
    output logic [PPB_COUNT-1:0]      ppb_out,             // persistent bits
    output logic                      suspend_refused_out  // one-cycle pulse
);

    typedef enum logic [2:0] {
        OPK_ERASE,
        OPK_PROG_CFG,
        OPK_CLEAR_LOCK,
        OPK_SET_HOLD,
        OPK_PROG_SECRET,
        OPK_UNLOCK
    } spp_kind_t;

    logic [15:0]          cfg;
    logic [7:0]           lock;
    logic [63:0]          secret;
    logic                 secret_set;
    logic [PPB_COUNT-1:0] persistent_protection_bit;
    logic                 write_in_progress_flag;
    logic                 write_enable_latch;

    ////////////////////////////////////////////////////////////////////////////
    // link clock domain

    // frame flag and miso drivers are cleared whenever chip select is high
    wire frame_rst_n = nrst_in & ~link.cs_n;

    logic [7:0]  bit_cnt;
    logic        over;
    logic        in_frame;
    logic [7:0]  opcode;
    logic [63:0] shift;
    logic [1:0]  wip_sync;
    logic [1:0]  wel_sync;

    // marks that the current frame has seen its first rising edge
    always_ff @(posedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    // rising-edge bit counter; over marks frames past 255 bits
    // count is kept after deselect so the system side can judge the length
    always_ff @(posedge link.sck or negedge nrst_in) begin
        if (!nrst_in) begin
            bit_cnt <= 8'h00;
            over    <= 1'b0;
        end else if (!in_frame) begin
            bit_cnt <= 8'h01;
            over    <= 1'b0;
        end else begin
            bit_cnt <= bit_cnt + 8'h01;
            if (bit_cnt == 8'hff) begin
                over <= 1'b1;
            end
        end
    end

    always_ff @(posedge link.sck or negedge nrst_in) begin
        if (!nrst_in) begin
            opcode <= 8'h00;
            shift  <= 64'h0;
        end else begin
            shift <= {shift[62:0], link.mosi};
            if (!in_frame || (bit_cnt < FRAME_OP_BITS)) begin
                opcode <= {opcode[6:0], link.mosi};
            end
        end
    end

    // status bits change in the other domain; the opcode covers the sync delay
    always_ff @(posedge link.sck or negedge nrst_in) begin
        if (!nrst_in) begin
            wip_sync <= 2'b00;
            wel_sync <= 2'b00;
        end else begin
            wip_sync <= {wip_sync[0], write_in_progress_flag};
            wel_sync <= {wel_sync[0], write_enable_latch};
        end
    end

    // read data selection; position wraps modulo the register width
    wire [7:0] out_pos      = bit_cnt - FRAME_OP_BITS;
    wire [5:0] sidx         = stream_idx(out_pos[6:0]);
    wire [7:0] status_word  = {6'h00, wel_sync[1], wip_sync[1]};
    wire       secret_open  = secret_set & cfg[CFG_SECRET_MODE_BIT];
    wire       in_data      = (bit_cnt >= FRAME_OP_BITS) | over;

    logic rd_bit;
    logic rd_on;
    always_comb begin
        rd_bit = 1'b0;
        rd_on  = 1'b0;
        case (opcode)
            OP_READ_STATUS: begin
                rd_bit = status_word[sidx[2:0]];
                rd_on  = in_data;
            end
            OP_READ_PROT: begin
                rd_bit = cfg[sidx[3:0]];
                rd_on  = in_data;
            end
            OP_READ_LOCK: begin
                rd_bit = lock[sidx[2:0]];
                rd_on  = in_data;
            end
            OP_READ_SECRET: begin
                rd_bit = secret[sidx];
                rd_on  = in_data & secret_open;
            end
            default: begin
                rd_bit = 1'b0;
                rd_on  = 1'b0;
            end
        endcase
    end

    // shift out on falling edges; registers are read live, so an operation that completes mid-read changes the bits sent
    always_ff @(negedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            link.miso    <= 1'b0;
            link.miso_oe <= 1'b0;
        end else begin
            link.miso    <= rd_on ? rd_bit : 1'b0;
            link.miso_oe <= rd_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system clock domain

    logic cs_meta;
    logic cs_sync;
    logic cs_prev;

    // chip select crosses by two flops; the frame words are quiet by then
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= link.cs_n;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    wire frame_end = cs_sync & ~cs_prev;
    wire exact_op  = ~over & (bit_cnt == FRAME_OP_BITS);
    wire exact_cfg = ~over & (bit_cnt == FRAME_PROT_BITS);
    wire exact_sec = ~over & (bit_cnt == FRAME_SECRET_BITS);
    wire idle_end  = frame_end & ~write_in_progress_flag;

    logic      start;
    spp_kind_t next_kind;
    // secret program only outside secret mode
    always_comb begin
        start     = 1'b0;
        next_kind = OPK_ERASE;
        case (opcode)
            OP_ERASE_PERSIST: begin
                start     = idle_end & write_enable_latch & exact_op;
                next_kind = OPK_ERASE;
            end
            OP_PROG_PROT: begin
                start     = idle_end & write_enable_latch & exact_cfg;
                next_kind = OPK_PROG_CFG;
            end
            OP_CLEAR_LOCK: begin
                start     = idle_end & write_enable_latch & exact_op;
                next_kind = OPK_CLEAR_LOCK;
            end
            OP_SET_HOLD: begin
                start     = idle_end & write_enable_latch & exact_op;
                next_kind = OPK_SET_HOLD;
            end
            OP_PROG_SECRET: begin
                start     = idle_end & write_enable_latch & exact_sec & cfg[CFG_SECRET_MODE_BIT];
                next_kind = OPK_PROG_SECRET;
            end
            OP_UNLOCK_SECRET: begin
                start     = idle_end & exact_sec;
                next_kind = OPK_UNLOCK;
            end
            default: begin
                start     = 1'b0;
                next_kind = OPK_ERASE;
            end
        endcase
    end

    // host bit stream back to value order
    function automatic logic [63:0] unpack(input logic [63:0] d);
        logic [63:0] v;
        v = 64'h0;
        for (int i = 0; i < 64; i++) begin
            v[stream_idx(7'(i))] = d[63-i];
        end
        return v;
    endfunction : unpack

    spp_kind_t   kind;
    logic [63:0] data;
    logic [15:0] timer;
    wire         done = write_in_progress_flag & (timer == 16'h0000);

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            write_in_progress_flag   <= 1'b0;
            write_enable_latch   <= 1'b0;
            kind  <= OPK_ERASE;
            data  <= 64'h0;
            timer <= 16'h0000;
        end else if (start) begin
            write_in_progress_flag   <= 1'b1;
            kind  <= next_kind;
            data  <= shift;
            timer <= (next_kind == OPK_ERASE) ? 16'(ERASE_CYCLES - 1) : 16'(PROG_CYCLES - 1);
        end else if (done) begin
            write_in_progress_flag <= 1'b0;
            if (kind != OPK_UNLOCK) begin
                write_enable_latch <= 1'b0;
            end
        end else if (write_in_progress_flag) begin
            timer <= timer - 16'h0001;
        end else if (idle_end & exact_op & (opcode == OP_WRITE_ENABLE)) begin
            write_enable_latch <= 1'b1;
        end
    end

    wire [63:0] data_val = unpack(data);

    // effects land only when the timed operation completes
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg        <= CFG_RESET;
            lock       <= LOCK_RESET;
            secret     <= SECRET_RESET;
            secret_set <= 1'b0;
            persistent_protection_bit        <= '1;
        end else if (done) begin
            case (kind)
                OPK_ERASE:       persistent_protection_bit <= '1;
                // second byte is the high byte
                OPK_PROG_CFG:    cfg <= {data[7:0], data[15:8]};
                OPK_CLEAR_LOCK:  lock[LOCK_PERSIST_BIT] <= 1'b0;
                OPK_SET_HOLD:    lock[LOCK_HOLD_BIT] <= 1'b1;
                OPK_PROG_SECRET: begin
                    secret     <= data_val;
                    secret_set <= 1'b1;
                end
                OPK_UNLOCK: begin
                    if (data_val == secret) begin
                        lock[LOCK_PERSIST_BIT] <= 1'b1;
                    end
                end
                default: begin
                    persistent_protection_bit <= persistent_protection_bit;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            suspend_refused_out <= 1'b0;
        end else begin
            suspend_refused_out <= frame_end & write_in_progress_flag & (kind == OPK_ERASE)
                                   & exact_op & (opcode == OP_ERASE_SUSPEND);
        end
    end

    // user-side views
    assign wip_out  = write_in_progress_flag;
    assign wel_out  = write_enable_latch;
    assign cfg_out  = cfg;
    assign lock_out = lock;
    assign ppb_out  = persistent_protection_bit;

endmodule : spp_device

// ### core/spp_host.sv
module spp_host
    import spp_pkg::*;
#(
    parameter int HALF_CYCLES = SCK_HALF_CYCLES,
    parameter int GAP_CYCLES  = CS_GAP_CYCLES
) (
    input  wire logic        sys_clk_in,    // host clock
    input  wire logic        nrst_in,       // async reset, active low
    spp_if.host              link,          // serial link to the device
    input  wire logic        cmd_valid_in,  // command request
    output logic             cmd_ready_out, // idle, request taken
    input  wire logic [7:0]  cmd_op_in,     // opcode
    input  wire logic [6:0]  cmd_wbits_in,  // data bits to send, 0..64
    input  wire logic [63:0] cmd_wdata_in,  // data value to send
    input  wire logic [6:0]  cmd_rbits_in,  // data bits to read, 0..64
    output logic             rsp_valid_out, // one-cycle pulse, frame done
    output logic [63:0]      rsp_data_out   // read value
);

    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} spp_hstate_t;

    spp_hstate_t state;
    logic [7:0]  op;
    logic [63:0] wdata;
    logic [7:0]  wend;
    logic [7:0]  total;
    logic [7:0]  pos;
    logic [15:0] phase;
    logic [1:0]  miso_sync;

    // opcode then data, low byte first
    function automatic logic bit_for(input logic [7:0] p, input logic [7:0] o,
                                     input logic [63:0] w, input logic [7:0] we);
        logic [7:0] dp;
        dp = p - 8'h08;
        if (p < 8'h08) begin
            return o[3'(7 - p)];
        end
        if (p < we) begin
            return w[stream_idx(dp[6:0])];
        end
        return 1'b0;
    endfunction : bit_for

    wire [7:0] rpos    = pos - wend;
    wire [7:0] pos_inc = pos + 8'h01;
    wire       phase_0 = (phase == 16'h0000);

    // commands go out in the order given
    assign cmd_ready_out = (state == H_IDLE);

    // miso is clocked by the device; two flops before use
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            miso_sync <= 2'b00;
        end else begin
            miso_sync <= {miso_sync[0], link.miso};
        end
    end

    // frame sequencer, sck idles low
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state         <= H_IDLE;
            op            <= 8'h00;
            wdata         <= 64'h0;
            wend          <= 8'h00;
            total         <= 8'h00;
            pos           <= 8'h00;
            phase         <= 16'h0000;
            link.cs_n     <= 1'b1;
            link.sck      <= 1'b0;
            link.mosi     <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= 64'h0;
        end else begin
            rsp_valid_out <= 1'b0;
            phase         <= phase_0 ? 16'(HALF_CYCLES - 1) : phase - 16'h0001;
            case (state)
                H_IDLE: begin
                    if (cmd_valid_in) begin
                        op           <= cmd_op_in;
                        wdata        <= cmd_wdata_in;
                        wend         <= 8'h08 + {1'b0, cmd_wbits_in};
                        total        <= 8'h08 + {1'b0, cmd_wbits_in} + {1'b0, cmd_rbits_in};
                        pos          <= 8'h00;
                        phase        <= 16'(HALF_CYCLES - 1);
                        rsp_data_out <= 64'h0;
                        link.cs_n    <= 1'b0;
                        link.mosi    <= cmd_op_in[7];
                        state        <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (phase_0) begin
                        link.sck <= 1'b1;
                        state    <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (phase_0) begin
                        link.sck <= 1'b0;
                        if (pos >= wend) begin
                            rsp_data_out[stream_idx(rpos[6:0])] <= miso_sync[1];
                        end
                        if (pos_inc == total) begin
                            state <= H_TAIL;
                        end else begin
                            pos       <= pos_inc;
                            link.mosi <= bit_for(pos_inc, op, wdata, wend);
                            state     <= H_LOW;
                        end
                    end
                end
                // deselect one half period after the last falling edge
                H_TAIL: begin
                    if (phase_0) begin
                        link.cs_n <= 1'b1;
                        link.mosi <= 1'b0;
                        phase     <= 16'(GAP_CYCLES - 1);
                        state     <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (phase_0) begin
                        rsp_valid_out <= 1'b1;
                        state         <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

endmodule : spp_host

// ### testbench/spp_link_chk.sv
module spp_link_chk (
    input  wire logic sys_clk_in, // host clock
    input  wire logic nrst_in,    // async reset, active low
    input  wire logic cs_n,       // chip select, active low
    input  wire logic sck,        // link clock
    input  wire logic mosi,       // host data
    input  wire logic miso,       // device data
    input  wire logic miso_oe     // device drives miso
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       sck_q;
    logic [7:0] bit_cnt;
    wire  [7:0] next_bit_cnt;

    // rising link edges per frame; sampled on the host clock since sck is derived from it
    assign next_bit_cnt = cs_n ? 8'h00 : bit_cnt + {7'h00, sck & ~sck_q};

    // edge history and bit count
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sck_q   <= 1'b0;
            bit_cnt <= 8'h00;
        end else begin
            sck_q   <= sck;
            bit_cnt <= next_bit_cnt;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    ////////////////////////////////////////////////////////////////////////////////
    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("link clock moved while deselected");
    a_mosi_hold_high: assert property ((sck && $past(sck)) |-> $stable(mosi))
        else $error("host data changed while link clock high");
    a_sck_high_len: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("link clock high phase not four cycles");
    a_cs_gap_len: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("deselect gap too short");
    a_cs_lead_in: assert property ($fell(cs_n) |-> !sck [*3] ##[1:2] sck)
        else $error("first link edge not four cycles after select");
    a_frame_whole_bytes: assert property ($rose(cs_n) |-> (bit_cnt[2:0] == 3'h0) && (bit_cnt != 8'h00))
        else $error("frame did not end on a byte boundary");
    a_miso_quiet_off: assert property (!miso_oe |-> !miso)
        else $error("device data active while not driving");
    a_oe_deselect_off: assert property ((cs_n && $past(cs_n)) |-> !miso_oe)
        else $error("device drives while deselected");
    a_miso_hold_high: assert property ((sck && $past(sck)) |-> $stable(miso))
        else $error("device data changed while link clock high");

    // main traffic shapes
    c_read_frame: cover property ($rose(miso_oe));
    c_cfg_frame: cover property ($rose(cs_n) && bit_cnt == 8'h18);
    c_secret_frame: cover property ($rose(cs_n) && bit_cnt == 8'h48);
endmodule : spp_link_chk

// ### testbench/tb_sector_protection_password_cmds.sv
module tb_sector_protection_password_cmds import spp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk_in   = 1'b0;
    logic        nrst_in      = 1'b1;
    logic        cmd_valid_in = 1'b0;
    logic [7:0]  cmd_op_in    = 8'h00;
    logic [6:0]  cmd_wbits_in = 7'h00;
    logic [63:0] cmd_wdata_in = 64'h0;
    logic [6:0]  cmd_rbits_in = 7'h00;
    wire         cmd_ready_out, rsp_valid_out, wip_out, wel_out, suspend_refused_out;
    wire  [63:0] rsp_data_out;
    wire  [15:0] cfg_out;
    wire  [7:0]  lock_out;
    wire  [31:0] ppb_out;
    int          fails = 0, tests_run = 0, seed = 51, refusals = 0;
    logic [63:0] exp_q[$];
    logic [63:0] sec;
    logic [15:0] v;
    logic [7:0]  ops[5] = '{OP_PROG_PROT, OP_ERASE_PERSIST, OP_CLEAR_LOCK, OP_SET_HOLD,
                            OP_PROG_SECRET};
    logic [6:0]  wbs[5] = '{7'h10, 7'h00, 7'h00, 7'h00, 7'h40};

    always #12.5 sys_clk_in = ~sys_clk_in;

    spp_if spp_if_i ();
    spp_host spp_host_i (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .link(spp_if_i),
        .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in),
        .cmd_wbits_in(cmd_wbits_in), .cmd_wdata_in(cmd_wdata_in), .cmd_rbits_in(cmd_rbits_in),
        .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out));
    spp_device spp_device_i (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .link(spp_if_i),
        .wip_out(wip_out), .wel_out(wel_out), .cfg_out(cfg_out), .lock_out(lock_out),
        .ppb_out(ppb_out), .suspend_refused_out(suspend_refused_out));
    spp_link_chk spp_link_chk_i (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .cs_n(spp_if_i.cs_n), .sck(spp_if_i.sck), .mosi(spp_if_i.mosi),
        .miso(spp_if_i.miso), .miso_oe(spp_if_i.miso_oe));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    // one whole frame; request held until the host takes it, reply noted first
    task automatic xfer(input logic [7:0] op, input logic [6:0] wb, input logic [63:0] wd,
                        input logic [6:0] rb, input logic [63:0] want);
        int n;
        @(posedge sys_clk_in);
        cmd_valid_in <= 1'b1;
        cmd_op_in    <= op;
        cmd_wbits_in <= wb;
        cmd_wdata_in <= wd;
        cmd_rbits_in <= rb;
        exp_q.push_back(want);
        n = 0;
        do begin @(negedge sys_clk_in); n++; end while (cmd_ready_out !== 1'b1 && n < 100);
        if (cmd_ready_out !== 1'b1) begin fails++; complete_run(); end
        @(posedge sys_clk_in);
        cmd_valid_in <= 1'b0;
        n = 0;
        do begin @(negedge sys_clk_in); n++; end while (rsp_valid_out !== 1'b1 && n < 1500);
        if (n >= 1500) begin fails++; complete_run(); end
    endtask : xfer

    // bounded wait for the timed operation to finish
    task automatic wait_idle();
        int n;
        repeat (2) @(negedge sys_clk_in);
        n = 0;
        while (wip_out !== 1'b0 && n < 1000) begin @(negedge sys_clk_in); n++; end
        if (n >= 1000) begin fails++; complete_run(); end
    endtask : wait_idle

    // latch first, then the modifying frame, then wait it out
    // latch before modify
    task automatic guarded(input logic [7:0] op, input logic [6:0] wb, input logic [63:0] wd);
        xfer(OP_WRITE_ENABLE, 7'h00, 64'h0, 7'h00, 64'h0);
        check(64'(wel_out), 64'h1);
        xfer(op, wb, wd, 7'h00, 64'h0);
        wait_idle();
    endtask : guarded

    ////////////////////////////////////////////////////////////////////////////////
    // every reply is judged against the oldest note, in arrival order
    always @(negedge sys_clk_in) begin
        if (rsp_valid_out === 1'b1) begin
            if (exp_q.size() > 0)
                check(rsp_data_out, exp_q.pop_front());
            else
                fails++;
        end
        if (suspend_refused_out === 1'b1)
            refusals++;
    end

    initial begin
        nrst_in <= 1'b0;
        repeat (16) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        @(negedge sys_clk_in);
        check({48'h0, cfg_out}, 64'(CFG_RESET));
        check({56'h0, lock_out}, 64'(LOCK_RESET));
        check({32'h0, ppb_out}, 64'hffff_ffff);
        check({62'h0, wel_out, wip_out}, 64'h0);
        // each of the five latch-guarded codes refused without the latch
        for (int i = 0; i < 5; i++) begin
            xfer(ops[i], wbs[i], {$random(seed), $random(seed)}, 7'h00, 64'h0);
            check({62'h0, wel_out, wip_out}, 64'h0);
            check({lock_out, cfg_out, ppb_out}, {8'h01, 16'hffff, 32'hffff_ffff});
        end
        // config program and read back twice
        v = 16'($random(seed)) | 16'h0004;
        guarded(OP_PROG_PROT, 7'h10, {48'h0, v});
        check({47'h0, wel_out, cfg_out}, {48'h0, v});
        xfer(OP_READ_PROT, 7'h00, 64'h0, 7'h20, {32'h0, v, v});
        // frames of the wrong length are dropped
        xfer(OP_WRITE_ENABLE, 7'h00, 64'h0, 7'h00, 64'h0);
        xfer(OP_PROG_PROT, 7'h08, {48'h0, ~v}, 7'h00, 64'h0);
        xfer(OP_ERASE_PERSIST, 7'h08, 64'h0, 7'h00, 64'h0);
        check({46'h0, wel_out, wip_out, cfg_out}, {46'h0, 2'b10, v});
        xfer(OP_ERASE_PERSIST, 7'h00, 64'h0, 7'h00, 64'h0);
        xfer(OP_READ_STATUS, 7'h00, 64'h0, 7'h08, 64'h3);
        xfer(OP_ERASE_SUSPEND, 7'h00, 64'h0, 7'h00, 64'h0);
        check(64'(refusals), 64'h1);
        wait_idle();
        check({31'h0, wel_out, ppb_out}, 64'hffff_ffff);
        xfer(OP_READ_STATUS, 7'h00, 64'h0, 7'h08, 64'h0);
        // lock changes, read only when idle
        guarded(OP_CLEAR_LOCK, 7'h00, 64'h0);
        check({55'h0, wel_out, lock_out}, 64'h0);
        xfer(OP_READ_LOCK, 7'h00, 64'h0, 7'h10, 64'h0);
        guarded(OP_SET_HOLD, 7'h00, 64'h0);
        check({55'h0, wel_out, lock_out}, 64'h80);
        xfer(OP_READ_LOCK, 7'h00, 64'h0, 7'h10, 64'h8080);
        sec = {$random(seed), $random(seed)};
        guarded(OP_PROG_SECRET, 7'h40, sec);
        check(64'(wel_out), 64'h0);
        xfer(OP_READ_SECRET, 7'h00, 64'h0, 7'h40, sec);
        xfer(OP_UNLOCK_SECRET, 7'h40, sec ^ 64'h1, 7'h00, 64'h0);
        wait_idle();
        check({56'h0, lock_out}, 64'h80);
        xfer(OP_UNLOCK_SECRET, 7'h40, sec, 7'h00, 64'h0);
        wait_idle();
        check({56'h0, lock_out}, 64'h81);
        // secret mode hides and freezes the secret
        guarded(OP_PROG_PROT, 7'h10, {48'h0, v & 16'hfffb});
        check({48'h0, cfg_out}, {48'h0, v & 16'hfffb});
        xfer(OP_READ_SECRET, 7'h00, 64'h0, 7'h40, 64'h0);
        guarded(OP_PROG_SECRET, 7'h40, ~sec);
        check({62'h0, wel_out, wip_out}, 64'h2);
        complete_run();
    end
endmodule : tb_sector_protection_password_cmds
